// >>> sbp_defs.svh
// Purpose: Constants for the serial peripheral bridge port
// Assumes: 20 MHz system clock
// Notes:   Mode codes and widths used by the port logic
// What this block does
// - Four modes from polarity and phase
// - Idle clock level equals polarity
// - Mode 0: sample rising, shift falling
// - Mode 1: sample falling, shift rising
// - Mode 2: sample falling, shift rising
// - Mode 3: sample rising, shift falling
// - Slave moves plain bytes, no handshake
// - Select release abandons slave transfer
// - Slave select active low, clock and data
// - No slave data before enumeration completes
// - Fault output high until enumeration done
// - Master supports full duplex only
// - Master clock programmable rate and mode
// - Master drives one active-low select
// - At most one interface active, chosen by pins
// - Master shifts and captures only in the shift stage
// - Pure data pipe, no command decode
`ifndef SBP_DEFS_SVH
`define SBP_DEFS_SVH
`define SBP_BYTE_W      8
`define SBP_CNT_W       3
`define SBP_DIV_W       8
`define SBP_SEL_SLAVE   2'h1
`define SBP_SEL_MASTER  2'h2
`define SBP_LAST_BIT    3'h7
`endif

// >>> sbp_far.sv
// Purpose: Far side model: external master and slave of the port
// Assumes: Mode is stable while a frame runs
// Notes:   Released data lines show the inverse of the last bit
`timescale 1ns/1ps
`default_nettype none
module sbp_far
  import sbp_pkg::*;
(
  input  wire sbp_mode_s  mode_in,    // Polarity and phase
  input  wire logic [7:0] base_in,    // First reply byte
  output logic            sclk_out,   // Clock to slave port
  output logic            ssel_n_out, // Select to slave port
  output logic            mosi_out,   // Data to slave port
  input  wire logic       miso_in,    // Data from slave port
  input  wire logic       mclk_in,    // Clock from master port
  input  wire logic       msel_n_in,  // Select from master port
  input  wire logic       mmosi_in,   // Data from master port
  output logic            mmiso_out   // Data to master port
);
  logic [7:0] rx_reg;
  logic [7:0] cur;
  int         n;
  int         k;
  logic [7:0] got[$];
  initial
  begin
    sclk_out = 1'b0;
    ssel_n_out = 1'b1;
    mosi_out = 1'b0;
    mmiso_out = 1'b0;
  end
  always @(negedge msel_n_in)
  begin
    n = 0;
    k = 0;
    mmiso_out = base_in[7];
  end
  always @(posedge msel_n_in)
    mmiso_out = ~mmiso_out;
  // Sample edge when clock level differs from polarity xor phase
  always @(mclk_in)
    if (!msel_n_in)
    begin
      if (mclk_in ^ mode_in.cpol ^ mode_in.cpha)
      begin
        rx_reg = {rx_reg[6:0], mmosi_in};
        n++;
        if (n == 8)
        begin
          got.push_back(rx_reg);
          n = 0;
          k++;
        end
      end
      else
      begin
        cur = base_in + 8'(k);
        mmiso_out = cur[7-n];
      end
    end
  // Select low opens a frame, high closes it; clock rests at polarity
  task automatic frame(input logic open);
    if (open)
    begin
      sclk_out = mode_in.cpol;
      #200;
      ssel_n_out = 1'b0;
      #400;
    end
    else
    begin
      #400;
      ssel_n_out = 1'b1;
      mosi_out = ~mosi_out;
    end
  endtask
  task automatic xfer(input logic [7:0] d, input int nb,
                      output logic [7:0] q);
    q = 8'h00;
    for (int i = 7; i > 7 - nb; i--)
    begin
      if (mode_in.cpha)
        sclk_out = ~sclk_out;
      mosi_out = d[i];
      #200;
      sclk_out = ~sclk_out;
      q[i] = miso_in;
      #200;
      if (!mode_in.cpha)
        sclk_out = ~sclk_out;
    end
  endtask
endmodule
`default_nettype wire

// >>> sbp_pkg.sv
// Purpose: Types for the serial peripheral bridge port
// Assumes: Included constants header
// Notes:   None
package sbp_pkg;
  typedef enum logic [1:0] {SBP_IDLE, SBP_LEAD, SBP_SHIFT, SBP_DONE} sbp_mst_e;
  typedef struct packed {
    logic cpol;
    logic cpha;
  } sbp_mode_s;
endpackage

// >>> sbp_port.sv
// Purpose: Serial peripheral slave and master port with byte pipes
// Assumes: Link pins asynchronous, sampled by two flip-flops
// Notes:   Slave clock must be well below a quarter of the system clock
`timescale 1ns/1ps
`default_nettype none
`include "sbp_defs.svh"
module sbp_port
  import sbp_pkg::*;
#(
  parameter int DIV_W = `SBP_DIV_W
)(
  input  wire logic              sys_clk_in,            // System clock
  input  wire logic              srst_in,               // Sync reset
  input  wire logic [1:0]        interface_select_pins_in, // Mode pins
  input  wire sbp_mode_s         mode_in,               // Polarity/phase
  input  wire logic [DIV_W-1:0]  clk_div_in,            // Half period
  input  wire logic              enum_done_in,          // USB enumerated
  input  wire logic              slave_pin_clock_in,    // Slave clock
  input  wire logic              slave_pin_select_n_in, // Slave select
  input  wire logic              slave_pin_data_in,     // Slave MOSI
  output logic                   slave_pin_data_out,    // Slave MISO
  output logic                   mst_clk_out,           // Master clock
  output logic                   mst_sel_n_out,         // Master select
  output logic                   mst_mosi_out,          // Master MOSI
  input  wire logic              mst_miso_in,           // Master MISO
  output logic                   link_fault_out,        // High until enum
  input  wire logic              tx_valid_in,           // Byte to send
  input  wire logic [7:0]        tx_data_in,            // Byte value
  input  wire logic              tx_last_in,            // End master frame
  output logic                   tx_ready_out,          // Byte taken
  output logic                   rx_valid_out,          // Byte received
  output logic [7:0]             rx_data_out            // Received value
);
  logic slave_en;
  logic master_en;
  assign slave_en  = (interface_select_pins_in == `SBP_SEL_SLAVE);
  assign master_en = (interface_select_pins_in == `SBP_SEL_MASTER) &&
                     !slave_en;

  // Link fault indicator
  logic fault_reg;
  logic fault_next;
  always_comb fault_next = !enum_done_in;
  always_ff @(posedge sys_clk_in)
    if (srst_in) fault_reg <= 1'b1;
    else fault_reg <= fault_next;
  assign link_fault_out = fault_reg;

  // Pin synchronisers
  logic [2:0] s1_reg;
  logic [2:0] s2_reg;
  logic [2:0] s3_reg;
  logic [2:0] s_pins;
  logic       m1_reg;
  logic       m2_reg;
  assign s_pins = {slave_pin_clock_in, slave_pin_select_n_in,
                   slave_pin_data_in};
  always_ff @(posedge sys_clk_in)
    if (srst_in)
    begin
      s1_reg <= 3'h3 << 1;
      s2_reg <= 3'h3 << 1;
      s3_reg <= 3'h3 << 1;
      m1_reg <= 1'b0;
      m2_reg <= 1'b0;
    end
    else
    begin
      s1_reg <= s_pins;
      s2_reg <= s1_reg;
      s3_reg <= s2_reg;
      m1_reg <= mst_miso_in;
      m2_reg <= m1_reg;
    end
  logic sclk;
  logic sclk_d;
  logic ssel_n;
  logic smosi;
  assign sclk   = s2_reg[2];
  assign sclk_d = s3_reg[2];
  assign ssel_n = s2_reg[1];
  assign smosi  = s2_reg[0];
  logic s_rise;
  logic s_fall;
  logic s_samp;
  logic s_shft;
  logic s_act;
  assign s_rise = sclk && !sclk_d;
  assign s_fall = !sclk && sclk_d;
  // Sample edge is rising when polarity equals phase
  logic same_pol;
  assign same_pol = (mode_in.cpol == mode_in.cpha);
  assign s_samp = same_pol ? s_rise : s_fall;
  assign s_shft = same_pol ? s_fall : s_rise;
  assign s_act  = slave_en && !ssel_n && !fault_reg;

  // Slave shifter
  logic [7:0] sr_reg;
  logic [7:0] sr_next;
  logic [7:0] st_reg;
  logic [7:0] st_next;
  logic [2:0] sc_reg;
  logic [2:0] sc_next;
  logic       sdone;
  logic       sload;
  logic       sload_reg;
  logic       sload_next;
  always_comb
  begin
    sr_next    = sr_reg;
    st_next    = st_reg;
    sc_next    = sc_reg;
    sdone      = 1'b0;
    sload      = 1'b0;
    sload_next = sload_reg;
    if (!s_act)
    begin
      sc_next    = 3'h0;
      sload_next = 1'b1;
    end
    else
    begin
      if (sload_reg)
      begin
        sload      = 1'b1;
        sload_next = 1'b0;
        st_next    = tx_valid_in ? tx_data_in : 8'h00;
      end
      if (s_samp)
      begin
        sr_next = {sr_reg[6:0], smosi};
        sc_next = sc_reg + 3'h1;
        if (sc_reg == `SBP_LAST_BIT)
        begin
          sdone      = 1'b1;
          sload_next = 1'b1;
        end
      end
      // Bit 7 stands from the load; the edge at a byte boundary holds it
      if (s_shft && !sload_reg && sc_reg != 3'h0)
        st_next = {st_next[6:0], 1'b0};
    end
  end
  always_ff @(posedge sys_clk_in)
    if (srst_in)
    begin
      sr_reg    <= 8'h00;
      st_reg    <= 8'h00;
      sc_reg    <= 3'h0;
      sload_reg <= 1'b1;
    end
    else
    begin
      sr_reg    <= sr_next;
      st_reg    <= st_next;
      sc_reg    <= sc_next;
      sload_reg <= sload_next;
    end
  assign slave_pin_data_out = st_reg[7];

  // Master engine
  sbp_mst_e         ms_reg;
  sbp_mst_e         ms_next;
  logic [DIV_W-1:0] dv_reg;
  logic [DIV_W-1:0] dv_next;
  logic [2:0]       mc_reg;
  logic [2:0]       mc_next;
  logic [7:0]       mt_reg;
  logic [7:0]       mt_next;
  logic [7:0]       mr_reg;
  logic [7:0]       mr_next;
  logic             mk_reg;
  logic             mk_next;
  logic             half_reg;
  logic             half_next;
  logic             last_reg;
  logic             last_next;
  logic             mdone;
  logic             mtake;
  logic             tick;
  assign tick = (dv_reg == '0);
  always_comb
  begin
    ms_next   = ms_reg;
    dv_next   = tick ? clk_div_in : dv_reg - 1'b1;
    mc_next   = mc_reg;
    mt_next   = mt_reg;
    mr_next   = mr_reg;
    mk_next   = mk_reg;
    half_next = half_reg;
    last_next = last_reg;
    mdone     = 1'b0;
    mtake     = 1'b0;
    case (ms_reg)
      SBP_IDLE:
      begin
        mk_next   = mode_in.cpol;
        half_next = 1'b0;
        if (master_en && tx_valid_in)
        begin
          mtake     = 1'b1;
          mt_next   = tx_data_in;
          last_next = tx_last_in;
          mc_next   = 3'h0;
          dv_next   = clk_div_in;
          ms_next   = SBP_LEAD;
        end
      end
      SBP_LEAD:
        if (tick)
          ms_next = SBP_SHIFT;
      SBP_SHIFT:
        if (tick)
        begin
          mk_next   = !mk_reg;
          half_next = !half_reg;
          // First half edge samples in phase 0, shifts in phase 1
          if (half_reg == mode_in.cpha)
          begin
            mr_next = {mr_reg[6:0], m2_reg};
            if (!mode_in.cpha)
              mc_next = mc_reg + 3'h1;
          end
          else if (mode_in.cpha)
          begin
            if (mc_reg != 3'h0 || half_reg)
              mt_next = {mt_reg[6:0], 1'b0};
          end
          else
            mt_next = {mt_reg[6:0], 1'b0};
          if (mode_in.cpha && !half_reg && half_reg != mode_in.cpha)
            mc_next = mc_reg + 3'h1;
          if (half_reg && mc_reg == 3'h0 && mk_next == mode_in.cpol &&
              (mode_in.cpha || mc_next == 3'h0))
            ms_next = SBP_DONE;
        end
      SBP_DONE:
      begin
        mdone = 1'b1;
        mk_next = mode_in.cpol;
        if (!last_reg && tx_valid_in && master_en)
        begin
          mtake     = 1'b1;
          mt_next   = tx_data_in;
          last_next = tx_last_in;
          dv_next   = clk_div_in;
          ms_next   = SBP_LEAD;
        end
        else if (last_reg || !master_en)
          ms_next = SBP_IDLE;
      end
      default: ms_next = SBP_IDLE;
    endcase
  end
  always_ff @(posedge sys_clk_in)
    if (srst_in)
    begin
      ms_reg   <= SBP_IDLE;
      dv_reg   <= '0;
      mc_reg   <= 3'h0;
      mt_reg   <= 8'h00;
      mr_reg   <= 8'h00;
      mk_reg   <= 1'b0;
      half_reg <= 1'b0;
      last_reg <= 1'b0;
    end
    else
    begin
      ms_reg   <= ms_next;
      dv_reg   <= dv_next;
      mc_reg   <= mc_next;
      mt_reg   <= mt_next;
      mr_reg   <= mr_next;
      mk_reg   <= mk_next;
      half_reg <= half_next;
      last_reg <= last_next;
    end
  assign mst_clk_out   = mk_reg;
  assign mst_sel_n_out = (ms_reg == SBP_IDLE);
  assign mst_mosi_out  = mt_reg[7];
  assign tx_ready_out  = mtake || sload;

  // Receive output pipe
  logic       rv_reg;
  logic       rv_next;
  logic [7:0] rd_reg;
  logic [7:0] rd_next;
  always_comb
  begin
    rv_next = sdone || mdone;
    rd_next = sdone ? sr_next : (mdone ? mr_reg : rd_reg);
  end
  always_ff @(posedge sys_clk_in)
    if (srst_in)
    begin
      rv_reg <= 1'b0;
      rd_reg <= 8'h00;
    end
    else
    begin
      rv_reg <= rv_next;
      rd_reg <= rd_next;
    end
  assign rx_valid_out = rv_reg;
  assign rx_data_out  = rd_reg;

  property p_fault_reset;
    @(posedge sys_clk_in) disable iff (srst_in)
      enum_done_in |=> !link_fault_out;
  endproperty
  a_fault_reset: assert property (p_fault_reset)
    else $error("fault output not cleared");
  property p_idle_clock;
    @(posedge sys_clk_in) disable iff (srst_in)
      (ms_reg == SBP_IDLE) ##1 (ms_reg == SBP_IDLE) |->
        mst_clk_out == $past(mode_in.cpol);
  endproperty
  a_idle_clock: assert property (p_idle_clock)
    else $error("idle master clock wrong level");
  property p_abort;
    @(posedge sys_clk_in) disable iff (srst_in)
      ssel_n |=> sc_reg == 3'h0;
  endproperty
  a_abort: assert property (p_abort)
    else $error("slave count kept after select release");
  property p_rx_pulse;
    @(posedge sys_clk_in) disable iff (srst_in)
      sdone |=> rx_valid_out && rx_data_out == $past(sr_next);
  endproperty
  a_rx_pulse: assert property (p_rx_pulse)
    else $error("slave byte not delivered");
  property p_no_slave_early;
    @(posedge sys_clk_in) disable iff (srst_in)
      fault_reg |-> !sdone;
  endproperty
  a_no_slave_early: assert property (p_no_slave_early)
    else $error("slave byte before enumeration");
  property p_one_iface;
    @(posedge sys_clk_in) disable iff (srst_in)
      !(slave_en && master_en);
  endproperty
  a_one_iface: assert property (p_one_iface)
    else $error("two interfaces active");
  property p_sel_frame;
    @(posedge sys_clk_in) disable iff (srst_in)
      mtake && ms_reg == SBP_IDLE |=> !mst_sel_n_out;
  endproperty
  a_sel_frame: assert property (p_sel_frame)
    else $error("select not asserted at start");
  property p_clock_toggle;
    @(posedge sys_clk_in) disable iff (srst_in)
      ms_reg == SBP_SHIFT && tick |=> mst_clk_out != $past(mst_clk_out);
  endproperty
  a_clock_toggle: assert property (p_clock_toggle)
    else $error("master clock did not toggle");
endmodule
`default_nettype wire

// >>> tb.sv
// Purpose: Self-checking bench of the serial bridge port
// Assumes: Far side model drives both link ends
// Notes:   Random data from a fixed-seed shift register
`timescale 1ns/1ps
`default_nettype none
module tb
  import sbp_pkg::*;
  ;
  logic sys_clk_in = 1'b0;
  logic srst_in, enum_done_in, tx_valid_in, tx_last_in, tx_ready_out;
  logic rx_valid_out, s_clk, s_sel_n, s_mosi, s_miso;
  logic m_clk, m_sel_n, m_mosi, m_miso, link_fault_out;
  logic [1:0] pins;
  logic [7:0] clk_div_in, tx_data_in, rx_data_out, base, d;
  sbp_mode_s mode;
  logic [31:0] lfsr;
  logic [8:0] txq[$];
  logic [7:0] rxq[$], sent[$], ans[$], tq[$], eq[$];
  int failures, checked, w;
  always #25 sys_clk_in = ~sys_clk_in;
  sbp_port i_dut (.sys_clk_in(sys_clk_in), .srst_in(srst_in),
    .interface_select_pins_in(pins), .mode_in(mode),
    .clk_div_in(clk_div_in), .enum_done_in(enum_done_in),
    .slave_pin_clock_in(s_clk), .slave_pin_select_n_in(s_sel_n),
    .slave_pin_data_in(s_mosi), .slave_pin_data_out(s_miso),
    .mst_clk_out(m_clk), .mst_sel_n_out(m_sel_n), .mst_mosi_out(m_mosi),
    .mst_miso_in(m_miso), .link_fault_out(link_fault_out),
    .tx_valid_in(tx_valid_in), .tx_data_in(tx_data_in),
    .tx_last_in(tx_last_in), .tx_ready_out(tx_ready_out),
    .rx_valid_out(rx_valid_out), .rx_data_out(rx_data_out));
  sbp_far i_far (.mode_in(mode), .base_in(base), .sclk_out(s_clk),
    .ssel_n_out(s_sel_n), .mosi_out(s_mosi), .miso_in(s_miso),
    .mclk_in(m_clk), .msel_n_in(m_sel_n), .mmosi_in(m_mosi),
    .mmiso_out(m_miso));
  // Byte source toward the port and collector of received bytes
  always @(posedge sys_clk_in)
  begin
    if (tx_valid_in && tx_ready_out)
      void'(txq.pop_front());
    if (rx_valid_out)
      rxq.push_back(rx_data_out);
    #2;
    tx_valid_in = (txq.size() > 0);
    {tx_last_in, tx_data_in} = (txq.size() > 0) ? txq[0] : 9'h000;
  end
  function automatic logic [7:0] rnd();
    lfsr = {lfsr[30:0], lfsr[31] ^ lfsr[21] ^ lfsr[1] ^ lfsr[0]};
    return lfsr[7:0];
  endfunction
  function automatic logic [7:0] reply(input logic [7:0] b, input int k);
    return b + 8'(k);
  endfunction
  task automatic chk(input logic [7:0] got, input logic [7:0] exp,
                     input string what);
    checked++;
    if (got !== exp)
    begin
      failures++;
      $display("wrong value at %0t: %s got %h expected %h", $time, what,
               got, exp);
    end
  endtask
  task automatic cmpq(input logic [7:0] a[$], input logic [7:0] b[$],
                      input string what);
    chk(8'(a.size()), 8'(b.size()), what);
    foreach (b[i])
      if (i < a.size())
        chk(a[i], b[i], what);
  endtask
  task automatic sframe(input int nb, input int cut);
    logic [7:0] q;
    sent = {};
    ans = {};
    rxq = {};
    i_far.frame(1'b1);
    for (int b = 0; b < nb; b++)
    begin
      d = rnd();
      i_far.xfer(d, (b == nb - 1) ? cut : 8, q);
      if (b < nb - 1 || cut == 8)
        sent.push_back(d);
      ans.push_back(q);
    end
    i_far.frame(1'b0);
    repeat (4) @(posedge sys_clk_in);
    #2;
  endtask
  task automatic conclude();
    $display("checked %0d failures %0d", checked, failures);
    if (failures == 0 && checked > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  initial
  begin
    srst_in = 1'b1;
    pins = 2'h1;
    mode = '0;
    clk_div_in = 8'h03;
    enum_done_in = 1'b0;
    tx_valid_in = 1'b0;
    tx_data_in = 8'h00;
    tx_last_in = 1'b0;
    base = 8'h00;
    lfsr = 32'h2be6db7f;
    failures = 0;
    checked = 0;
    repeat (20) @(posedge sys_clk_in);
    #2;
    srst_in = 1'b0;
    chk(8'(link_fault_out), 8'h01, "fault in reset");
    chk(8'(m_sel_n), 8'h01, "master select");
    sframe(1, 8);
    chk(8'(rxq.size()), 8'h00, "rx before enum");
    enum_done_in = 1'b1;
    repeat (2) @(posedge sys_clk_in);
    #2;
    chk(8'(link_fault_out), 8'h00, "fault after enum");
    for (int m = 0; m < 4; m++)
    begin
      mode = sbp_mode_s'(m[1:0]);
      tq = {};
      for (int j = 0; j < 3; j++)
        tq.push_back(rnd());
      foreach (tq[j])
        txq.push_back({1'b0, tq[j]});
      sframe(3, 8);
      cmpq(rxq, sent, "slave rx");
      cmpq(ans, tq, "slave tx");
      sframe(2, 4);
      cmpq(rxq, sent, "aborted frame");
      sframe(1, 8);
      cmpq(rxq, sent, "after abort");
      chk(ans[0], 8'h00, "empty fill");
      chk(8'(m_sel_n), 8'h01, "master quiet");
    end
    pins = 2'h0;
    sframe(1, 8);
    chk(8'(rxq.size()), 8'h00, "no interface");
    pins = 2'h2;
    for (int m = 0; m < 4; m++)
    begin
      mode = sbp_mode_s'(m[1:0]);
      d = rnd();
      clk_div_in = 8'h03 + {6'h00, d[1:0]};
      base = rnd();
      repeat (4) @(posedge sys_clk_in);
      #2;
      chk(8'(m_clk), 8'(mode.cpol), "idle clock");
      chk(8'(m_sel_n), 8'h01, "idle select");
      tq = {};
      eq = {};
      rxq = {};
      i_far.got = {};
      for (int j = 0; j <= m; j++)
      begin
        tq.push_back(rnd());
        eq.push_back(reply(base, j));
        txq.push_back({1'(j == m), tq[j]});
      end
      for (w = 0; w < 5000; w++)
      begin
        @(posedge sys_clk_in);
        #2;
        if (txq.size() == 0 && m_sel_n === 1'b1 && rxq.size() > m)
          break;
      end
      if (w == 5000)
      begin
        failures++;
        conclude();
      end
      cmpq(i_far.got, tq, "master out");
      cmpq(rxq, eq, "master in");
      chk(8'(i_far.n), 8'h00, "bit count");
    end
    conclude();
  end
endmodule
`default_nettype wire
